// File: hdl/tmosc_defines.svh
`ifndef TMOSC_DEFINES_SVH
`define TMOSC_DEFINES_SVH
// ************************************************************
// otp word map
// ************************************************************
`define TMOSC_OTP_SEC_T0       11'h000
`define TMOSC_OTP_SEC_T1_UNI   11'h001
`define TMOSC_OTP_USER_ID      11'h004
`define TMOSC_OTP_SPLIT_BASE   11'h400
`define TMOSC_OTP_SEC_T1_SPL   11'h401
`define TMOSC_OTP_SPLIT_RES_HI 11'h404
`define TMOSC_OTP_RES_LO       11'h002
`define TMOSC_OTP_RES_HI       11'h003
// ************************************************************
// security word fields
// ************************************************************
`define TMOSC_SEC_JTAG_OFF     0
`define TMOSC_SEC_PLL_OFF      4
`define TMOSC_SEC_SECURE_BOOT  5
`define TMOSC_SEC_UNIFIED      7
`define TMOSC_SEC_WRITE_OFF    8
`define TMOSC_SEC_RSVD         9
`define TMOSC_SEC_DEBUG_OFF    14
// ************************************************************
// usercode placement and memory windows
// ************************************************************
`define TMOSC_UID_LSB          18
`define TMOSC_UID_W            14
`define TMOSC_SWMEM_LO         32'h40000000
`define TMOSC_SWMEM_HI         32'h7FFFFFFF
`define TMOSC_BOOT_OTP_ADDR    11'h000
`endif

// File: hdl/tmosc_pkg.sv
`default_nettype none
package tmosc_pkg;
  typedef struct packed {
    logic jtag_off;
    logic pll_off;
    logic secure_boot;
    logic unified;
    logic write_off;
    logic debug_off;
  } tmosc_sec_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [2:0]  size;
    logic [31:0] be;
    logic [255:0] wdata;
  } tmosc_mreq_t;

  typedef enum logic [2:0] {
    TMOSC_SZ_BYTE,
    TMOSC_SZ_HALF,
    TMOSC_SZ_WORD,
    TMOSC_SZ_DWORD,
    TMOSC_SZ_VEC
  } tmosc_size_t;
endpackage
`default_nettype wire

// File: hdl/tmosc_sram.sv
`include "tmosc_defines.svh"
`default_nettype none
module tmosc_sram
  import tmosc_pkg::*;
#(
  parameter int DEPTH  = 16384,
  parameter int AW     = 14
)(
  input  wire logic         i_clk,
  input  wire logic         i_en,
  input  wire logic         i_we,
  input  wire logic [AW-1:0] i_row,
  input  wire logic [31:0]  i_be,
  input  wire logic [255:0] i_wdata,
  output logic [255:0]      o_rdata
);
  logic [255:0] mem [DEPTH];

  // every access width resolves in one cycle via lane enables
  always_ff @(posedge i_clk)
  begin
    if (i_en)
    begin
      for (int b = 0; b < 32; b++)
      begin
        if (i_we && i_be[b])
          mem[i_row][b*8 +: 8] <= i_wdata[b*8 +: 8];
      end
      o_rdata <= mem[i_row];
    end
  end
endmodule
`default_nettype wire

// File: hdl/tmosc_otp.sv
`include "tmosc_defines.svh"
`default_nettype none
module tmosc_otp
  import tmosc_pkg::*;
#(
  parameter int WORDS = 1024,
  parameter int AW    = 11
)(
  input  wire logic          i_clk,
  input  wire logic          i_prog_en,
  input  wire logic [AW-1:0] i_prog_addr,
  input  wire logic [31:0]   i_prog_data,
  input  wire logic [AW-1:0] i_rd_addr,
  output logic [31:0]        o_rd_data
);
  // one-time bits: programming may only set, never clear
  logic [31:0] mem [WORDS];

  initial
  begin
    for (int i = 0; i < WORDS; i++)
      mem[i] = 32'h00000000;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_prog_en)
      mem[i_prog_addr] <= mem[i_prog_addr] | i_prog_data;
    o_rd_data <= mem[i_rd_addr];
  end
endmodule
`default_nettype wire

// File: hdl/tmosc_top.sv
// Notes on behaviour
// [R1] 512KB SRAM, 256 wide, single-cycle access
// [R2] 0x40000000-0x7FFFFFFF routed to software memory
// [R3] 8KB OTP outside the normal address space
// [R4] split mode hides OTP upper half
// [R5] unified map: sec0, sec1, reserved, user word
// [R6] user word bits 13:0 to usercode 31:18
// [R7] split map: tile1 security at 0x401
// [R8] bit 0 blocks scan access
// [R9] bit 4 refuses scan PLL writes
// [R10] bit 5 forces boot from OTP 0
// [R11] bit 7 unified, disables 0x400-0x404
// [R12] bit 8 write inhibit, bit 14 debug
// [R13] programming only via dedicated ports
// [R14] user id valid only after reset
// [R15] sample security once after reset
`include "tmosc_defines.svh"
`default_nettype none
module tmosc_top
  import tmosc_pkg::*;
#(
  parameter int          SRAM_AW  = 14,
  parameter int          OTP_AW   = 11,
  parameter int          OTP_WORDS = 2048,
  parameter logic [17:0] USER_LOW = 18'h00A04
)(
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_tile_sel,
  input  wire tmosc_mreq_t  i_mreq,
  output logic [255:0]      o_mem_rdata,
  output logic              o_mem_rvalid,
  output logic              o_swmem_req,
  output logic [31:0]       o_swmem_addr,
  input  wire logic         i_otp_rd_en,
  input  wire logic [10:0]  i_otp_rd_addr,
  output logic [31:0]       o_otp_rd_data,
  output logic              o_otp_rd_valid,
  output logic              o_otp_rd_err,
  input  wire logic         i_prog_en,
  input  wire logic [10:0]  i_prog_addr,
  input  wire logic [31:0]  i_prog_data,
  output logic              o_prog_refused,
  input  wire logic         i_scan_req,
  output logic              o_scan_grant,
  input  wire logic         i_scan_pll_we,
  output logic              o_pll_we,
  input  wire logic         i_debug_n,
  output logic              o_debug_req,
  input  wire logic [2:0]   i_boot_pins,
  output logic              o_boot_from_otp,
  output logic [10:0]       o_boot_otp_addr,
  output logic [2:0]        o_boot_src,
  output logic              o_cfg_ready,
  output tmosc_sec_t        o_sec,
  output logic [31:0]       o_usercode
);
  // ************************************************************
  // reset-time security capture
  // ************************************************************
  typedef enum logic [2:0] {
    TMOSC_RD_SEC0,
    TMOSC_WAIT_SEC0,
    TMOSC_WAIT_SEC1,
    TMOSC_WAIT_UID,
    TMOSC_DONE
  } tmosc_st_t;

  tmosc_st_t   st_ff;
  tmosc_st_t   nxt_st;
  logic [31:0] otp_q;
  logic [10:0] cap_addr;
  logic [10:0] otp_addr;
  logic [31:0] sec0_ff;
  logic        done;
  tmosc_sec_t  sec_ff;
  logic [13:0] uid_ff;
  logic        uid_vld_ff;
  logic [2:0]  boot_ff;

  assign done = (st_ff == TMOSC_DONE);

  always_comb
  begin
    nxt_st   = st_ff;
    cap_addr = `TMOSC_OTP_SEC_T0;
    case (st_ff)
      TMOSC_RD_SEC0:
      begin
        nxt_st = TMOSC_WAIT_SEC0;
      end
      TMOSC_WAIT_SEC0:
      begin
        // tile 1 word location depends on unified bit in tile 0 word
        cap_addr = otp_q[`TMOSC_SEC_UNIFIED] ? `TMOSC_OTP_SEC_T1_UNI : `TMOSC_OTP_SEC_T1_SPL;
        nxt_st   = TMOSC_WAIT_SEC1;
      end
      TMOSC_WAIT_SEC1:
      begin
        cap_addr = `TMOSC_OTP_USER_ID;
        nxt_st   = TMOSC_WAIT_UID;
      end
      TMOSC_WAIT_UID:
      begin
        nxt_st = TMOSC_DONE;
      end
      TMOSC_DONE:
      begin
        nxt_st = TMOSC_DONE;
      end
      default:
      begin
        nxt_st = TMOSC_RD_SEC0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st_ff <= TMOSC_RD_SEC0;
    else
      st_ff <= nxt_st;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      sec0_ff <= 32'h00000000;
    else if (st_ff == TMOSC_WAIT_SEC0)
      sec0_ff <= otp_q;
  end

  // [R15] capture once, hold till reset
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sec_ff <= '0;
    end
    else if (st_ff == TMOSC_WAIT_SEC1)
    begin
      // [R11] unified bit always from tile 0 word
      sec_ff.unified     <= sec0_ff[`TMOSC_SEC_UNIFIED];
      // [R8] per-tile scan disable
      sec_ff.jtag_off    <= i_tile_sel ? otp_q[`TMOSC_SEC_JTAG_OFF] : sec0_ff[`TMOSC_SEC_JTAG_OFF];
      sec_ff.pll_off     <= i_tile_sel ? otp_q[`TMOSC_SEC_PLL_OFF] : sec0_ff[`TMOSC_SEC_PLL_OFF];
      sec_ff.secure_boot <= i_tile_sel ? otp_q[`TMOSC_SEC_SECURE_BOOT] : sec0_ff[`TMOSC_SEC_SECURE_BOOT];
      // [R12] write inhibit and debug block
      sec_ff.write_off   <= i_tile_sel ? otp_q[`TMOSC_SEC_WRITE_OFF] : sec0_ff[`TMOSC_SEC_WRITE_OFF];
      sec_ff.debug_off   <= i_tile_sel ? otp_q[`TMOSC_SEC_DEBUG_OFF] : sec0_ff[`TMOSC_SEC_DEBUG_OFF];
    end
  end

  // [R14] user id only valid after capture
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      uid_ff     <= 14'h0000;
      uid_vld_ff <= 1'b0;
    end
    else if (st_ff == TMOSC_WAIT_UID)
    begin
      uid_ff     <= otp_q[`TMOSC_UID_W-1:0];
      uid_vld_ff <= 1'b1;
    end
  end

  // boot pins sampled just after reset, alongside security capture
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      boot_ff <= 3'h0;
    else if (st_ff == TMOSC_RD_SEC0)
      boot_ff <= i_boot_pins;
  end

  // ************************************************************
  // otp access window
  // ************************************************************
  logic rd_ok;
  logic rd_pend_ff;
  logic rd_err_ff;

  // [R4] split hides upper half; [R11] unified hides 0x400-0x404
  always_comb
  begin
    rd_ok = 1'b1;
    if (!sec_ff.unified && i_otp_rd_addr >= `TMOSC_OTP_SPLIT_BASE)
      rd_ok = 1'b0;
    if (sec_ff.unified && i_otp_rd_addr >= `TMOSC_OTP_SPLIT_BASE && i_otp_rd_addr <= `TMOSC_OTP_SPLIT_RES_HI)
      rd_ok = 1'b0;
    // [R5] reserved words 0x002-0x003
    if (i_otp_rd_addr >= `TMOSC_OTP_RES_LO && i_otp_rd_addr <= `TMOSC_OTP_RES_HI)
      rd_ok = 1'b0;
  end

  // [R7] split map tile 1 view sits above 0x400
  assign otp_addr = !done ? cap_addr : i_otp_rd_addr;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rd_pend_ff <= 1'b0;
      rd_err_ff  <= 1'b0;
    end
    else
    begin
      rd_pend_ff <= done && i_otp_rd_en && rd_ok;
      rd_err_ff  <= done && i_otp_rd_en && !rd_ok;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_otp_rd_data <= 32'h00000000;
    else if (rd_pend_ff)
      o_otp_rd_data <= otp_q;
  end

  assign o_otp_rd_err = rd_err_ff;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_otp_rd_valid <= 1'b0;
    else
      o_otp_rd_valid <= rd_pend_ff;
  end

  // [R13] programming enters only through the dedicated port
  // [R12] refused once write inhibit captured
  logic prog_go;
  assign prog_go = i_prog_en && done && !sec_ff.write_off;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_prog_refused <= 1'b0;
    else
      o_prog_refused <= i_prog_en && !prog_go;
  end

  // [R3] otp only on private ports, not on memory bus
  tmosc_otp #(
    .WORDS (OTP_WORDS),
    .AW    (OTP_AW)
  ) u_otp (
    .i_clk       (i_clk),
    .i_prog_en   (prog_go),
    .i_prog_addr (i_prog_addr),
    .i_prog_data (i_prog_data),
    .i_rd_addr   (otp_addr),
    .o_rd_data   (otp_q)
  );

  // ************************************************************
  // sram and software memory window
  // ************************************************************
  logic sw_hit;
  logic sram_en;

  // [R2] software memory decode
  assign sw_hit  = (i_mreq.addr >= `TMOSC_SWMEM_LO) && (i_mreq.addr <= `TMOSC_SWMEM_HI);
  assign sram_en = i_mreq.req && !sw_hit;

  // [R1] one row per cycle
  tmosc_sram #(
    .AW    (SRAM_AW),
    .DEPTH (1 << SRAM_AW)
  ) u_sram (
    .i_clk   (i_clk),
    .i_en    (sram_en),
    .i_we    (i_mreq.we),
    .i_row   (i_mreq.addr[SRAM_AW+4:5]),
    .i_be    (i_mreq.be),
    .i_wdata (i_mreq.wdata),
    .o_rdata (o_mem_rdata)
  );

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_mem_rvalid <= 1'b0;
    else
      o_mem_rvalid <= sram_en && !i_mreq.we;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_swmem_req  <= 1'b0;
      o_swmem_addr <= 32'h00000000;
    end
    else
    begin
      o_swmem_req  <= i_mreq.req && sw_hit;
      o_swmem_addr <= i_mreq.addr;
    end
  end

  // ************************************************************
  // decoded outputs
  // ************************************************************
  // [R8] scan blocked until capture, then by bit 0
  assign o_scan_grant    = i_scan_req && done && !sec_ff.jtag_off;
  // [R9] pll write refused
  assign o_pll_we        = i_scan_pll_we && done && !sec_ff.pll_off;
  // [R12] debug pin ignored when blocked
  assign o_debug_req     = !i_debug_n && done && !sec_ff.debug_off;
  // [R10] secure boot overrides boot pins
  assign o_boot_from_otp = done && sec_ff.secure_boot;
  assign o_boot_otp_addr = `TMOSC_BOOT_OTP_ADDR;
  assign o_boot_src      = (done && !sec_ff.secure_boot) ? boot_ff : 3'h0;
  assign o_cfg_ready     = done;
  assign o_sec           = sec_ff;
  // [R6] user id into usercode high bits
  assign o_usercode      = {(uid_vld_ff ? uid_ff : 14'h0000), USER_LOW};
endmodule
`default_nettype wire

// File: testbench/tmosc_chk.sv
`default_nettype none
module tmosc_chk
  import tmosc_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire tmosc_mreq_t i_mreq,
  input wire logic        o_swmem_req,
  input wire logic [31:0] o_swmem_addr,
  input wire logic        i_otp_rd_en,
  input wire logic [10:0] i_otp_rd_addr,
  input wire logic        o_otp_rd_err,
  input wire logic        i_prog_en,
  input wire logic        o_prog_refused,
  input wire logic        i_scan_req,
  input wire logic        o_scan_grant,
  input wire logic        i_scan_pll_we,
  input wire logic        o_pll_we,
  input wire logic        i_debug_n,
  input wire logic        o_debug_req,
  input wire logic        o_boot_from_otp,
  input wire logic [10:0] o_boot_otp_addr,
  input wire logic        o_cfg_ready,
  input wire tmosc_sec_t  o_sec
);
  // ********
  // ready timing, window and gating checks
  // ********
  logic [2:0] rel_cnt_ff;
  logic       sw_hit;
  assign sw_hit = i_mreq.req && i_mreq.addr[31:30] == 2'h1;
  // saturates so a long run never wraps back under four
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rel_cnt_ff <= 3'h0;
    else if (rel_cnt_ff != 3'h7)
      rel_cnt_ff <= rel_cnt_ff + 3'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_ready_after_four: assert property (o_cfg_ready == (rel_cnt_ff >= 3'h4))
    else $error("config ready at wrong cycle");
  a_sw_window: assert property (sw_hit |=> o_swmem_req && o_swmem_addr == $past(i_mreq.addr))
    else $error("window access not forwarded");
  a_sw_outside: assert property (!sw_hit |=> !o_swmem_req)
    else $error("forward outside window");
  a_scan_gate: assert property (o_scan_grant |-> i_scan_req && !o_sec.jtag_off)
    else $error("scan granted while blocked");
  a_pll_gate: assert property (o_pll_we |-> i_scan_pll_we && !o_sec.pll_off)
    else $error("pll write passed while blocked");
  a_debug_gate: assert property (o_debug_req |-> !i_debug_n && !o_sec.debug_off)
    else $error("debug passed while blocked");
  a_secure_boot: assert property (o_cfg_ready && o_sec.secure_boot |-> o_boot_from_otp && o_boot_otp_addr == 11'h000)
    else $error("secure boot not from otp zero");
  a_reserved_err: assert property (i_otp_rd_en && o_cfg_ready && i_otp_rd_addr[10:1] == 10'h001 |=> o_otp_rd_err)
    else $error("reserved otp word not refused");
  a_prog_refuse: assert property (i_prog_en && o_cfg_ready && o_sec.write_off |=> o_prog_refused)
    else $error("locked programming not refused");
  cover property (sw_hit);
  cover property (o_prog_refused);
  cover property (o_cfg_ready && o_sec.secure_boot);
endmodule
bind tmosc_top tmosc_chk tmosc_chk_inst (.*);
`default_nettype wire

// File: testbench/tmosc_prog_agent.sv
`default_nettype none
module tmosc_prog_agent
(
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [10:0] i_addr,
  input  wire logic [31:0] i_data,
  output logic             o_prog_en,
  output logic [10:0]      o_prog_addr,
  output logic [31:0]      o_prog_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // programming agent
  // ********
  initial
  begin
    o_prog_en = 1'b0;
    o_prog_addr = 11'h000;
    o_prog_data = 32'h00000000;
  end
  // reserved bit cleared
  // idle data toggles so a stale word is never mistaken for a new one
  // only security words carry the reserved bit; user words pass untouched
  always @(negedge i_clk)
  begin
    o_prog_en <= i_go;
    o_prog_addr <= i_addr;
    if (!i_go)
      o_prog_data <= ~o_prog_data;
    else if (i_addr == 11'h000 || i_addr == 11'h001 || i_addr == 11'h401)
      o_prog_data <= i_data & ~32'h00000200;
    else
      o_prog_data <= i_data;
  end
endmodule
`default_nettype wire

// File: testbench/tmosc_top_tb.sv
`default_nettype none
module tmosc_top_tb
  import tmosc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0]  USER_LOW = 18'h00A04;
  localparam logic [255:0] W1 = {8{32'h12345678}};
  logic         i_clk, i_sys_rst, i_tile_sel, i_otp_rd_en, i_prog_en, i_scan_req, i_scan_pll_we, i_debug_n, go;
  logic [10:0]  i_otp_rd_addr, i_prog_addr, go_addr, o_boot_otp_addr;
  logic [31:0]  i_prog_data, go_data, o_otp_rd_data, o_swmem_addr, o_usercode;
  logic [2:0]   i_boot_pins, o_boot_src;
  logic [255:0] o_mem_rdata;
  logic         o_mem_rvalid, o_swmem_req, o_otp_rd_valid, o_otp_rd_err, o_prog_refused;
  logic         o_scan_grant, o_pll_we, o_debug_req, o_boot_from_otp, o_cfg_ready;
  tmosc_mreq_t  i_mreq;
  tmosc_sec_t   o_sec;
  int           n_fail, comparisons;
  tmosc_top #(.USER_LOW(USER_LOW)) tmosc_top_inst (.*);
  tmosc_prog_agent tmosc_prog_agent_inst (.i_clk(i_clk), .i_go(go), .i_addr(go_addr), .i_data(go_data),
    .o_prog_en(i_prog_en), .o_prog_addr(i_prog_addr), .o_prog_data(i_prog_data));
  // ********
  // access tasks
  // ********
  task chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task do_reset(input logic tile);
    @(negedge i_clk);
    i_sys_rst = 1'b1;
    i_tile_sel = tile;
    repeat (20) @(negedge i_clk);
    chk("ready in reset", o_cfg_ready, 1'b0);
    chk("usercode in reset", o_usercode, {14'h0000, USER_LOW});
    i_sys_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk("ready", o_cfg_ready, 1'b1);
  endtask
  // caller releases req, so back to back calls never drive it twice in one step
  task mem(input logic we, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] be, input logic [255:0] d);
    i_mreq = '{1'b1, we, a, sz, be, d};
    @(negedge i_clk);
  endtask
  task otp_rd(input logic [10:0] a, input logic err, input logic [31:0] d);
    i_otp_rd_addr = a;
    i_otp_rd_en = 1'b1;
    @(negedge i_clk);
    i_otp_rd_en = 1'b0;
    for (int i = 0; i < 4 && o_otp_rd_valid !== 1'b1 && o_otp_rd_err !== 1'b1; i++)
      @(negedge i_clk);
    chk("otp refusal", o_otp_rd_err, err);
    if (!err)
    begin
      chk("otp valid", o_otp_rd_valid, 1'b1);
      chk("otp data", o_otp_rd_data, d);
    end
    // one idle edge so back to back calls never re-drive the enable in one step
    @(negedge i_clk);
  endtask
  task prog(input logic [10:0] a, input logic [31:0] d);
    go_addr <= a;
    go_data <= d;
    go <= 1'b1;
    @(negedge i_clk);
    go <= 1'b0;
    @(negedge i_clk);
  endtask
  task test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ********
  // clock, watchdog, tests
  // ********
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    test_done;
  end
  initial
  begin
    logic [31:0] sw_a [4];
    sw_a = '{32'h3FFFFFFF, 32'h40000000, 32'h7FFFFFFF, 32'h80000000};
    {i_sys_rst, i_tile_sel, i_otp_rd_en, i_scan_req, i_scan_pll_we, i_debug_n, go} = 7'h42;
    i_mreq = '0;
    i_otp_rd_addr = 11'h000;
    go_addr = 11'h000;
    go_data = 32'h00000000;
    i_boot_pins = 3'h5;
    do_reset(1'b0);
    chk("blank security", o_sec, 6'h00);
    chk("boot source", o_boot_src, 3'h5);
    i_scan_req = 1'b1;
    i_scan_pll_we = 1'b1;
    i_debug_n = 1'b0;
    @(negedge i_clk);
    chk("scan open", o_scan_grant, 1'b1);
    chk("pll open", o_pll_we, 1'b1);
    chk("debug open", o_debug_req, 1'b1);
    mem(1'b1, 32'h00000040, 3'h4, 32'hFFFFFFFF, W1);
    mem(1'b0, 32'h00000040, 3'h4, 32'h00000000, 256'h0);
    chk("read valid", o_mem_rvalid, 1'b1);
    chk("row", o_mem_rdata, W1);
    mem(1'b1, 32'h00000040, 3'h0, 32'h00000001, {32{8'hEE}});
    mem(1'b0, 32'h00000040, 3'h0, 32'h00000000, 256'h0);
    chk("byte lane", o_mem_rdata, {W1[255:8], 8'hEE});
    for (int s = 0; s < 5; s++)
    begin
      mem(1'b0, 32'h00000040, s[2:0], 32'h00000000, 256'h0);
      chk("size read", o_mem_rvalid, 1'b1);
    end
    for (int i = 0; i < 4; i++)
    begin
      mem(1'b0, sw_a[i], 3'h2, 32'h00000000, 256'h0);
      chk("window forward", o_swmem_req, sw_a[i] >= 32'h40000000 && sw_a[i] <= 32'h7FFFFFFF);
      if (i == 1 || i == 2)
        chk("window addr", o_swmem_addr, sw_a[i]);
    end
    i_mreq.req = 1'b0;
    otp_rd(11'h002, 1'b1, 32'h0);
    otp_rd(11'h400, 1'b1, 32'h0);
    otp_rd(11'h7FF, 1'b1, 32'h0);
    otp_rd(11'h005, 1'b0, 32'h0);
    prog(11'h401, 32'h00000001);
    chk("prog accepted", o_prog_refused, 1'b0);
    do_reset(1'b1);
    chk("split tile1 word", o_sec, 6'b100000);
    chk("scan blocked", o_scan_grant, 1'b0);
    prog(11'h000, 32'h000042B1);
    prog(11'h001, 32'h00000100);
    prog(11'h004, 32'h00002ABC);
    prog(11'h005, 32'hCAFE0005);
    do_reset(1'b0);
    chk("unified tile0 word", o_sec, 6'b111101);
    chk("usercode id", o_usercode[31:18], 14'h2ABC);
    chk("scan blocked", o_scan_grant, 1'b0);
    chk("pll blocked", o_pll_we, 1'b0);
    chk("debug blocked", o_debug_req, 1'b0);
    chk("boot otp", o_boot_from_otp, 1'b1);
    chk("boot addr", o_boot_otp_addr, 11'h000);
    otp_rd(11'h000, 1'b0, 32'h000040B1);
    otp_rd(11'h005, 1'b0, 32'hCAFE0005);
    otp_rd(11'h400, 1'b1, 32'h0);
    otp_rd(11'h404, 1'b1, 32'h0);
    otp_rd(11'h003, 1'b1, 32'h0);
    do_reset(1'b1);
    chk("unified tile1 word", o_sec, 6'b000110);
    chk("scan open", o_scan_grant, 1'b1);
    prog(11'h006, 32'h00000001);
    chk("prog locked", o_prog_refused, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
